// File: common/pmp_pkg.sv
// Purpose: Shared constants and types for the port mode and page configuration block
// Assumes: One core clock, loads issued by the instruction decoder
// Notes:   Register identifiers are local selector codes, not bus addresses
package pmp_pkg;

    localparam int NIB_W = 4;

    // Load selector codes carried with each immediate load
    typedef enum logic [2:0]
    {
        PMP_LD_PAGE  = 3'h0,
        PMP_LD_PCE   = 3'h1,
        PMP_LD_DRIVE = 3'h2,
        PMP_LD_DIR1  = 3'h3,
        PMP_LD_DIR2  = 3'h4
    } pmp_ld_e;

    typedef struct packed
    {
        logic             valid;
        pmp_ld_e          sel;
        logic [NIB_W-1:0] imm;
    } pmp_load_s;

    // Values after reset
    localparam logic [NIB_W-1:0] PAGE_RST  = 4'h0;
    localparam logic [NIB_W-1:0] PCE_RST   = 4'h0;
    localparam logic [NIB_W-1:0] DRIVE_RST = 4'h0;
    localparam logic [NIB_W-1:0] DIR_RST   = 4'hf;

    // Field positions
    localparam int PAGE_LSB       = 0;
    localparam int PAGE_MSB       = 2;
    localparam int DRV_P1_OD_BIT  = 0;
    localparam int DRV_P2_OD_BIT  = 1;
    localparam int DRV_P3_PU_BIT  = 2;
    localparam int DRV_P4_PU_BIT  = 3;

    // Page offset width (16 nibble locations per page), address width
    localparam int PAGE_OFS_W = 4;
    localparam int DADDR_W    = 7;

endpackage

// File: logic/pmp_sync.sv
// Purpose: Two flip-flop synchroniser for a bus of pin levels
// Assumes: Inputs are asynchronous to core_clk_i
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module pmp_sync
#(
    parameter int W = 4
)
(
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         reset_i,
    // Data
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            meta_ff <= '0;
            sync_o  <= '0;
        end
        else
        begin
            meta_ff <= async_i;
            sync_o  <= meta_ff;
        end
    end
endmodule

// File: logic/pmp_chg_det.sv
// Purpose: Per-pin change detector gated by the change-enable bits
// Assumes: Input is already synchronised to core_clk_i
// Notes:   First sample after reset is taken without flagging
`timescale 1ns/1ps
module pmp_chg_det
#(
    parameter int W = 4
)
(
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         reset_i,
    // Pins and enables
    input  wire logic [W-1:0] pin_sync_i,
    input  wire logic [W-1:0] enable_i,
    output wire logic [W-1:0] change_o
);
    logic [W-1:0] prev_ff;
    logic         primed_ff;

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            prev_ff   <= '0;
            primed_ff <= 1'b0;
        end
        else
        begin
            prev_ff   <= pin_sync_i;
            primed_ff <= 1'b1;
        end
    end

    // Compare against previous sample, per pin
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_pin
            assign change_o[g] = primed_ff & enable_i[g]
                               & (pin_sync_i[g] ^ prev_ff[g]);
        end
    endgenerate
endmodule

// File: logic/pmp_top.sv
// Purpose: Page select, pin change enable and port mode registers
// Assumes: Loads come from the instruction decoder on core_clk_i, one per cycle
// Notes:   All registers are write only; their settings reach the outputs through one output register stage
//
// Behaviour
// - A page load stores the 4-bit immediate in the page register in one cycle.
// - Page bits 2..0 pick which 16-location data page indirect addressing reaches.
// - Only third-port pins with their change-enable bit set may wake hold or interrupt.
// - Drive bit 0 makes the first port push-pull when 0 and open-drain when 1.
// - Drive bit 1 makes the second port push-pull when 0 and open-drain when 1.
// - Drive bit 2 enables the third port pull-ups when 1.
// - Drive bit 3 enables the fourth port pull-ups when 1.
// - First direction bit n makes first port pin n an output at 0, input at 1.
// - First direction register resets to all ones.
// - Second direction bit n makes second port pin n an output at 0, input at 1.
// - Second direction register resets to all ones.
// - A drive load writes the immediate into the drive register in one cycle.
`timescale 1ns/1ps
module pmp_top
    import pmp_pkg::*;
#(
    parameter int PORT_W = 4
)
(
    // Clock and reset
    input  wire logic                  core_clk_i,
    input  wire logic                  reset_i,
    // Immediate load from decoder
    input  wire pmp_load_s             load_i,
    // Indirect addressing
    input  wire logic [PAGE_OFS_W-1:0] ind_ofs_i,
    output logic      [DADDR_W-1:0]    ind_addr_o,
    // Third port pins
    input  wire logic [PORT_W-1:0]     third_port_i,
    output logic                       pin_change_o,
    output logic      [PORT_W-1:0]     pin_change_vec_o,
    // Port modes
    output logic                       first_port_od_o,
    output logic                       second_port_od_o,
    output logic                       third_port_pu_o,
    output logic                       fourth_port_pu_o,
    output logic      [PORT_W-1:0]     first_port_dir_o,
    output logic      [PORT_W-1:0]     second_port_dir_o
);
    logic [NIB_W-1:0]  page_select_ff;
    logic [NIB_W-1:0]  pin_change_enable_ff;
    logic [NIB_W-1:0]  port_drive_config_ff;
    logic [PORT_W-1:0] first_port_direction_ff;
    logic [PORT_W-1:0] second_port_direction_ff;
    logic [PORT_W-1:0] third_sync;
    logic [PORT_W-1:0] chg_vec;

    // Write strobes
    wire wr_page  = load_i.valid && (load_i.sel == PMP_LD_PAGE);
    wire wr_pce   = load_i.valid && (load_i.sel == PMP_LD_PCE);
    wire wr_drive = load_i.valid && (load_i.sel == PMP_LD_DRIVE);
    wire wr_dir1  = load_i.valid && (load_i.sel == PMP_LD_DIR1);
    wire wr_dir2  = load_i.valid && (load_i.sel == PMP_LD_DIR2);

    // Page base plus offset; bit 3 dropped
    wire [DADDR_W-1:0] nxt_ind_addr =
        {page_select_ff[PAGE_MSB:PAGE_LSB], ind_ofs_i};

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            page_select_ff <= PAGE_RST;
        end
        else if (wr_page)
        begin
            page_select_ff <= load_i.imm;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pin_change_enable_ff <= PCE_RST;
        end
        else if (wr_pce)
        begin
            pin_change_enable_ff <= load_i.imm;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            port_drive_config_ff <= DRIVE_RST;
        end
        else if (wr_drive)
        begin
            port_drive_config_ff <= load_i.imm;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            first_port_direction_ff  <= DIR_RST;
            second_port_direction_ff <= DIR_RST;
        end
        else
        begin
            if (wr_dir1)
            begin
                first_port_direction_ff <= load_i.imm;
            end
            if (wr_dir2)
            begin
                second_port_direction_ff <= load_i.imm;
            end
        end
    end

    // Pin synchroniser and change detection
    pmp_sync #(.W(PORT_W)) u_sync
    (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    (third_port_i),
        .sync_o     (third_sync)
    );

    pmp_chg_det #(.W(PORT_W)) u_chg
    (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .pin_sync_i (third_sync),
        .enable_i   (pin_change_enable_ff),
        .change_o   (chg_vec)
    );

    // Registered outputs
    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ind_addr_o        <= '0;
            pin_change_o      <= 1'b0;
            pin_change_vec_o  <= '0;
            first_port_od_o   <= 1'b0;
            second_port_od_o  <= 1'b0;
            third_port_pu_o   <= 1'b0;
            fourth_port_pu_o  <= 1'b0;
            first_port_dir_o  <= DIR_RST;
            second_port_dir_o <= DIR_RST;
        end
        else
        begin
            ind_addr_o        <= nxt_ind_addr;
            pin_change_o      <= |chg_vec;
            pin_change_vec_o  <= chg_vec;
            first_port_od_o   <= port_drive_config_ff[DRV_P1_OD_BIT];
            second_port_od_o  <= port_drive_config_ff[DRV_P2_OD_BIT];
            third_port_pu_o   <= port_drive_config_ff[DRV_P3_PU_BIT];
            fourth_port_pu_o  <= port_drive_config_ff[DRV_P4_PU_BIT];
            first_port_dir_o  <= first_port_direction_ff;
            second_port_dir_o <= second_port_direction_ff;
        end
    end

    // Checks
    sequence s_page_load;
        load_i.valid && load_i.sel == PMP_LD_PAGE;
    endsequence

    // Second load repeats the low page bits
    sequence s_same_low_page;
        load_i.imm[PAGE_MSB:PAGE_LSB] == $past(load_i.imm[PAGE_MSB:PAGE_LSB]);
    endsequence

    AST_PAGE_LOAD: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_page_load |=> page_select_ff == $past(load_i.imm))
        else $error("page load not stored in one cycle");

    AST_PAGE_ADDR: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ##1 ind_addr_o == {$past(page_select_ff[2:0]), $past(ind_ofs_i)})
        else $error("indirect address wrong");

    AST_PAGE_RSVD: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_page_load ##1 (s_page_load and s_same_low_page)
        ##1 (ind_ofs_i == $past(ind_ofs_i)) |=> $stable(ind_addr_o))
        else $error("reserved page bit changed address");

    AST_CHG_MASK: assert property (@(posedge core_clk_i) disable iff (reset_i)
        pin_change_o |-> |($past(pin_change_enable_ff) & pin_change_vec_o))
        else $error("change flagged on disabled pin");

    AST_CHG_DET: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ($changed(third_sync) && (pin_change_enable_ff & (third_sync ^ $past(third_sync))) != 0
        && $past(!reset_i)) |=> pin_change_o)
        else $error("enabled pin change missed");

    AST_DRIVE_OUT: assert property (@(posedge core_clk_i) disable iff (reset_i)
        load_i.valid && load_i.sel == PMP_LD_DRIVE |-> ##2
        {fourth_port_pu_o, third_port_pu_o, second_port_od_o, first_port_od_o}
        == $past(load_i.imm, 2))
        else $error("drive config not applied");

    AST_P1_OD: assert property (@(posedge core_clk_i) disable iff (reset_i)
        first_port_od_o == $past(port_drive_config_ff[0]))
        else $error("first port drive type wrong");

    AST_DIR1: assert property (@(posedge core_clk_i) disable iff (reset_i)
        wr_dir1 |-> ##2 first_port_dir_o == $past(load_i.imm, 2))
        else $error("first port direction not applied");

    AST_DIR2: assert property (@(posedge core_clk_i) disable iff (reset_i)
        wr_dir2 |-> ##2 second_port_dir_o == $past(load_i.imm, 2))
        else $error("second port direction not applied");

    AST_DIR_RST: assert property (@(posedge core_clk_i)
        $fell(reset_i) |-> first_port_dir_o == DIR_RST && second_port_dir_o == DIR_RST)
        else $error("direction reset value wrong");
endmodule

// File: dv/pmp_pin_model.sv
// Purpose: External pin circuitry model driving the third port
// Assumes: Bench requests pin flips with a one-cycle toggle mask
// Notes:   Pins change a few ns after the edge, away from core sampling
`timescale 1ns/1ps
module pmp_pin_model
(
    // Clock
    input  wire logic       clk_i,
    // Request
    input  wire logic [3:0] toggle_i,
    // Pins
    output logic      [3:0] pin_o
);
    initial pin_o = 4'h0;

    // Flip requested pins, driven always, no release
    always @(posedge clk_i)
    begin
        if (toggle_i != 4'h0)
            pin_o <= #3 pin_o ^ toggle_i;
    end
endmodule

// File: dv/port_mode_and_page_config_bench.sv
// Purpose: Self-checking bench for the port mode and page block
// Assumes: Loads and pin flips are driven 1 ns after the rising edge
// Notes:   Drive outputs are checked one edge after the load is taken, direction outputs three to four edges after
`timescale 1ns/1ps
module port_mode_and_page_config_bench;
    import pmp_pkg::*;

    logic       core_clk = 1'b0;
    logic       reset    = 1'b1;
    pmp_load_s  load     = '0;
    logic [3:0] ind_ofs  = 4'h0;
    logic [3:0] toggle   = 4'h0;
    logic [3:0] third_port;
    logic [6:0] ind_addr;
    logic       chg;
    logic [3:0] chg_vec;
    logic       od1, od2, pu3, pu4;
    logic [3:0] dir1, dir2;
    int         error_cnt = 0;
    int         n_tests   = 0;

    always #4 core_clk = ~core_clk;

    pmp_top dut_u (.core_clk_i(core_clk), .reset_i(reset), .load_i(load),
        .ind_ofs_i(ind_ofs), .ind_addr_o(ind_addr), .third_port_i(third_port),
        .pin_change_o(chg), .pin_change_vec_o(chg_vec), .first_port_od_o(od1),
        .second_port_od_o(od2), .third_port_pu_o(pu3), .fourth_port_pu_o(pu4),
        .first_port_dir_o(dir1), .second_port_dir_o(dir2));

    pmp_pin_model pins_u (.clk_i(core_clk), .toggle_i(toggle), .pin_o(third_port));

    task automatic summarize();
        $display("Tests %0d, errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One load held for exactly one cycle, then one edge for outputs
    task automatic do_load(input pmp_ld_e sel, input logic [3:0] imm);
        @(posedge core_clk);
        #1 load = '{valid: 1'b1, sel: sel, imm: imm};
        @(posedge core_clk);
        #1 load.valid = 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    task automatic t_reset_vals();
        chk({4'h0, dir1}, 8'h0f);
        chk({4'h0, dir2}, 8'h0f);
        chk({4'h0, od1, od2, pu3, pu4}, 8'h00);
        chk({1'b0, ind_addr}, 8'h00);
    endtask

    task automatic t_drive();
        for (int i = 0; i < 16; i++)
        begin
            do_load(PMP_LD_DRIVE, i[3:0]);
            chk({7'h0, od1}, {7'h0, i[0]});
            chk({7'h0, od2}, {7'h0, i[1]});
            chk({7'h0, pu3}, {7'h0, i[2]});
            chk({7'h0, pu4}, {7'h0, i[3]});
        end
    endtask

    // Back-to-back direction loads, then an unknown selector ignored
    task automatic t_dirs();
        @(posedge core_clk);
        #1 load = '{valid: 1'b1, sel: PMP_LD_DIR1, imm: 4'h5};
        @(posedge core_clk);
        #1 load = '{valid: 1'b1, sel: PMP_LD_DIR2, imm: 4'ha};
        @(posedge core_clk);
        #1 load = '{valid: 1'b1, sel: pmp_ld_e'(3'h5), imm: 4'h0};
        @(posedge core_clk);
        #1 load.valid = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk({4'h0, dir1}, 8'h05);
        chk({4'h0, dir2}, 8'h0a);
    endtask

    task automatic t_page();
        for (int p = 0; p < 16; p++)
        begin
            do_load(PMP_LD_PAGE, p[3:0]);
            ind_ofs = p[3:0] ^ 4'h3;
            @(posedge core_clk);
            #1;
            chk({1'b0, ind_addr}, {1'b0, p[2:0], p[3:0] ^ 4'h3});
        end
    endtask

    // Back-to-back page loads differing only in the reserved bit
    task automatic t_page_rsvd();
        ind_ofs = 4'h9;
        @(posedge core_clk);
        #1 load = '{valid: 1'b1, sel: PMP_LD_PAGE, imm: 4'h2};
        @(posedge core_clk);
        #1 load.imm = 4'ha;
        @(posedge core_clk);
        #1 load.valid = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk({1'b0, ind_addr}, 8'h29);
    endtask

    // Flip pins, count pulses in a bounded window
    task automatic flip(input logic [3:0] m, input logic [7:0] n, input logic [3:0] v);
        logic [7:0] cnt;
        logic [3:0] acc;
        cnt = 8'h0;
        acc = 4'h0;
        @(posedge core_clk);
        #1 toggle = m;
        @(posedge core_clk);
        #1 toggle = 4'h0;
        for (int k = 0; k < 10; k++)
        begin
            @(posedge core_clk);
            #1;
            if (chg === 1'b1)
                cnt++;
            acc = acc | chg_vec;
        end
        chk(cnt, n);
        chk({4'h0, acc}, {4'h0, v});
    endtask

    task automatic t_change();
        do_load(PMP_LD_PCE, 4'h5);
        flip(4'h1, 8'h1, 4'h1);
        flip(4'h2, 8'h0, 4'h0);
        flip(4'h4, 8'h1, 4'h4);
        do_load(PMP_LD_PCE, 4'h0);
        flip(4'h1, 8'h0, 4'h0);
    endtask

    initial
    begin
        repeat (6) @(posedge core_clk);
        #1 reset = 1'b0;
        t_reset_vals();
        t_drive();
        t_dirs();
        t_page();
        t_page_rsvd();
        t_change();
        summarize();
    end

    initial
    begin
        #200000;
        error_cnt++;
        summarize();
    end
endmodule
